// File: rtl/serial_ctrl_pkg.sv
// Shared constants and types for the host serial control port
`default_nettype none

package serial_ctrl_pkg;

  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  localparam int          BYTE_BITS   = 8;
  localparam logic [4:0]  AC_BITS     = 5'h08;
  localparam logic [4:0]  BIT_CNT_MAX = 5'h1F;
  localparam logic [3:0]  REPLY_MSB   = 4'hF;

  // ----------------------------------------------------------------
  // Command classes by address/command byte value
  // ----------------------------------------------------------------
  localparam logic [7:0]  INSTR_LAST  = 8'h5F;
  localparam logic [7:0]  READ_FIRST  = 8'hE4;
  localparam logic [7:0]  TWO_FIRST   = 8'hD0;

  typedef enum logic [1:0] {KIND_INSTR, KIND_WRITE, KIND_READ} cmd_kind_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        SELECT_IDLE = 1'b1;
  localparam logic [15:0] REPLY_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          REF_CLK_PERIOD_NS = 50;
  localparam int          T_CSOFF_NS        = 1000;
  localparam logic [5:0]  CSOFF_CYCLES      =
    6'((T_CSOFF_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS);

endpackage

`default_nettype wire

// File: rtl/bit_sync.sv
// Two flip-flop level synchroniser
`default_nettype none

module bit_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic d,
  output logic      q
);

  logic meta_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_q <= RESET_VAL;
      q      <= RESET_VAL;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: rtl/cmd_classifier.sv
// Decodes an address/command byte into its class and data byte count
`default_nettype none

module cmd_classifier (
  input  wire logic                      [7:0] acByte,
  output serial_ctrl_pkg::cmd_kind_t           kind,
  output logic                           [1:0] dataBytes
);
  import serial_ctrl_pkg::*;

  wire isInstr = (acByte <= INSTR_LAST);
  wire isRead  = (acByte >= READ_FIRST);
  wire isTwo   = (acByte >= TWO_FIRST);

  assign kind      = isInstr ? KIND_INSTR : (isRead ? KIND_READ : KIND_WRITE);
  assign dataBytes = isInstr ? 2'h0 : (isTwo ? 2'h2 : 2'h1);

endmodule

`default_nettype wire

// File: rtl/host_serial_control_port.sv
// Slave end of the host serial control port with command hand-off to core logic
`default_nettype none

module host_serial_control_port (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        serialClk,
  input  wire logic                        select_low,
  input  wire logic                        cmdData,
  output logic                             reply_data,
  output logic                             reply_data_oe,
  input  wire logic                 [15:0] replyWord,
  output logic                             cmdValid,
  output serial_ctrl_pkg::cmd_kind_t       cmdKind,
  output logic                      [7:0]  cmdAddr,
  output logic                      [15:0] cmdWord,
  output logic                      [1:0]  cmdBytes,
  output logic                             frameError,
  output logic                             gapShort,
  output logic                             linkBusy
);
  import serial_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Link side: receive on the serial clock
  // ----------------------------------------------------------------
  // Select is timed against the serial clock by the bus (set-up and
  // hold around clock edges), so the link logic may read it directly.

  logic                  started_q;
  logic [4:0]            rxBits_q;
  logic [6:0]            shift_q;
  logic [7:0]            ac_q;
  logic [7:0]            data0_q;
  logic [7:0]            data1_q;
  logic                  frameTog_q;

  cmd_kind_t             acKind;
  logic      [1:0]       acBytes;

  wire       [4:0]       rxBitsInc  = (rxBits_q == BIT_CNT_MAX) ? BIT_CNT_MAX : rxBits_q + 5'h01;
  wire       [4:0]       rxBitsD    = started_q ? rxBitsInc : 5'h01;
  wire       [7:0]       byteNow    = {shift_q, cmdData};
  wire                   inFrame    = ~select_low;
  wire                   loadAc     = inFrame && (rxBitsD == 5'h08);
  wire                   loadData0  = inFrame && (rxBitsD == 5'h10);
  wire                   loadData1  = inFrame && (rxBitsD == 5'h18);

  // Marks that this frame has seen its first rising edge
  always_ff @(posedge serialClk or posedge select_low)
  begin
    if (select_low)
      started_q <= 1'b0;
    else
      started_q <= 1'b1;
  end

  // Bit counter and shifter; first edge of a frame restarts framing
  always_ff @(posedge serialClk)
  begin
    if (inFrame)
    begin
      rxBits_q <= rxBitsD;
      shift_q  <= byteNow[6:0];
    end
  end

  // Toggle announcing a frame with at least one bit to the core side.
  // The core reset clears it while the serial clock is quiet, so the
  // link and core copies of the toggle start from the same value.
  always_ff @(posedge serialClk or posedge reset)
  begin
    if (reset)
      frameTog_q <= 1'b0;
    else if (inFrame && !started_q)
      frameTog_q <= ~frameTog_q;
  end

  // Byte capture, most significant bit first
  always_ff @(posedge serialClk)
  begin
    if (loadAc)
      ac_q <= byteNow;
    if (loadData0)
      data0_q <= byteNow;
    if (loadData1)
      data1_q <= byteNow;
  end

  cmd_classifier u_classifier (
    .acByte    (ac_q),
    .kind      (acKind),
    .dataBytes (acBytes)
  );

  // ----------------------------------------------------------------
  // Link side: reply on the falling serial clock edge
  // ----------------------------------------------------------------
  // The reply holding word is written by the core only while it sees
  // select high, so it is stable during any frame that reads it.

  logic [15:0]           replyHold_q;

  wire        [15:0]     replyAligned = (acBytes == 2'h1) ? {replyHold_q[7:0], 8'h00} : replyHold_q;
  wire        [4:0]      replyOffset  = rxBits_q - AC_BITS;
  wire        [3:0]      replyIdx     = REPLY_MSB - replyOffset[3:0];
  wire        [4:0]      replyEnd     = AC_BITS + {acBytes, 3'b000};
  wire                   replyWindow  = started_q && (acKind == KIND_READ)
                                        && (rxBits_q >= AC_BITS) && (rxBits_q < replyEnd);

  // Enable and data change only on a falling edge; select high clears
  // both at once, so the line is released without waiting for a clock.
  always_ff @(negedge serialClk or posedge select_low)
  begin
    if (select_low)
    begin
      reply_data_oe <= 1'b0;
      reply_data    <= 1'b0;
    end
    else if (replyWindow)
    begin
      reply_data_oe <= 1'b1;
      reply_data    <= replyAligned[replyIdx];
    end
    else
    begin
      reply_data    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Core side: crossings
  // ----------------------------------------------------------------

  logic                  selSync;
  logic                  togSync;
  logic                  selPrev_q;
  logic                  togSeen_q;

  bit_sync #(
    .RESET_VAL (SELECT_IDLE)
  ) u_sel_sync (
    .clk   (ref_clk),
    .reset (reset),
    .d     (select_low),
    .q     (selSync)
  );

  bit_sync #(
    .RESET_VAL (1'b0)
  ) u_tog_sync (
    .clk   (ref_clk),
    .reset (reset),
    .d     (frameTog_q),
    .q     (togSync)
  );

  wire                   frameStart = selPrev_q && !selSync;
  wire                   frameEnd   = !selPrev_q && selSync;
  wire                   newFrame   = (togSync != togSeen_q);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      selPrev_q <= SELECT_IDLE;
    else
      selPrev_q <= selSync;
  end

  // Seen toggle follows the synced one when a frame closes
  always_ff @(posedge ref_clk)
  begin
    if (reset || frameEnd)
      togSeen_q <= togSync;
  end

  // Reply word is taken only while select is seen high
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      replyHold_q <= REPLY_RESET;
    else if (selSync)
      replyHold_q <= replyWord;
  end

  // ----------------------------------------------------------------
  // Core side: frame tracking
  // ----------------------------------------------------------------

  typedef enum {ST_IDLE, ST_FRAME} frame_state_t;

  frame_state_t          state_q;
  frame_state_t          state_d;
  logic [5:0]            gapCnt_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (frameStart)
          state_d = ST_FRAME;
      ST_FRAME:
        if (frameEnd)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Counts select-high time, saturating at the minimum gap
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      gapCnt_q <= CSOFF_CYCLES;
    else if (frameEnd)
      gapCnt_q <= 6'h01;
    else if (selSync && gapCnt_q != CSOFF_CYCLES)
      gapCnt_q <= gapCnt_q + 6'h01;
  end

  // ----------------------------------------------------------------
  // Core side: command hand-off at the end of a frame
  // ----------------------------------------------------------------
  // Link registers are quiet once select is high, so they are read
  // directly when the synchronised rise is seen.

  // Frames of 31 or more bits saturate the bit count, so overlong frames never look complete;
  // a frame with no clock edge leaves the toggle alone and is skipped.
  wire        [4:0]      expectBits = AC_BITS + {acBytes, 3'b000};
  wire                   complete   = (rxBits_q == expectBits);
  wire                   execute    = frameEnd && newFrame && complete;
  wire                   malformed  = frameEnd && newFrame && !complete;
  wire        [15:0]     wordNow    = (acBytes == 2'h2) ? {data0_q, data1_q}
                                    : (acBytes == 2'h1) ? {8'h00, data0_q} : 16'h0000;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cmdValid   <= 1'b0;
      frameError <= 1'b0;
      gapShort   <= 1'b0;
    end
    else
    begin
      cmdValid   <= execute;
      frameError <= malformed;
      gapShort   <= frameStart && (gapCnt_q != CSOFF_CYCLES);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cmdKind  <= KIND_INSTR;
      cmdAddr  <= 8'h00;
      cmdWord  <= 16'h0000;
      cmdBytes <= 2'h0;
    end
    else if (execute)
    begin
      cmdKind  <= acKind;
      cmdAddr  <= ac_q;
      cmdWord  <= wordNow;
      cmdBytes <= acBytes;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      linkBusy <= 1'b0;
    else
      linkBusy <= (state_d == ST_FRAME);
  end

endmodule

`default_nettype wire

// File: tb/host_serial_control_port_asserts.sv
// Checker for the host serial control port
`default_nettype none

module host_serial_control_port_asserts (
  input wire logic                       ref_clk,
  input wire logic                       reset,
  input wire logic                       serialClk,
  input wire logic                       select_low,
  input wire logic                       cmdData,
  input wire logic                       reply_data,
  input wire logic                       reply_data_oe,
  input wire logic                [15:0] replyWord,
  input wire logic                       cmdValid,
  input wire serial_ctrl_pkg::cmd_kind_t cmdKind,
  input wire logic                [7:0]  cmdAddr,
  input wire logic                [1:0]  cmdBytes,
  input wire logic                       frameError
);
  timeunit 1ns;
  timeprecision 100ps;
  import serial_ctrl_pkg::*;
  // ----------------------------------------------------------------
  // Link side shadow of framing
  // ----------------------------------------------------------------
  logic      [4:0]  riseCnt;
  logic      [7:0]  acShift;
  logic      [15:0] shadow;
  cmd_kind_t        expKind;
  wire logic [3:0]  replyIdx = 4'(5'h17 - riseCnt);
  wire logic [1:0]  expBytes = (cmdAddr <= INSTR_LAST) ? 2'h0 : (cmdAddr >= TWO_FIRST) ? 2'h2 : 2'h1;
  assign expKind = (cmdAddr <= INSTR_LAST) ? KIND_INSTR : (cmdAddr >= READ_FIRST) ? KIND_READ : KIND_WRITE;
  always_ff @(posedge serialClk or posedge select_low)
  begin
    if (select_low)
      riseCnt <= 5'h00;
    else if (riseCnt != 5'h1F)
      riseCnt <= riseCnt + 5'h01;
  end
  always_ff @(posedge serialClk)
  begin
    acShift <= {acShift[6:0], cmdData};
    if (riseCnt == 5'h00)
      shadow <= replyWord;
  end
  sequence s_release;
    ##[0:20] !reply_data_oe;
  endsequence
  a_oe_release: assert property (@(posedge ref_clk) disable iff (reset) $rose(select_low) |-> s_release)
    else $error("reply output still driven after select rose");
  a_exec_at_end: assert property (@(posedge ref_clk) disable iff (reset)
    cmdValid |-> select_low && $past(select_low) && $past(select_low, 2))
    else $error("command executed while select low");
  a_error_at_end: assert property (@(posedge ref_clk) disable iff (reset)
    frameError |-> select_low && $past(select_low) && $past(select_low, 2))
    else $error("frame error flagged while select low");
  a_valid_pulse: assert property (@(posedge ref_clk) disable iff (reset) cmdValid |=> !cmdValid)
    else $error("command valid longer than one cycle");
  a_kind_class: assert property (@(posedge ref_clk) disable iff (reset) cmdValid |-> cmdKind == expKind)
    else $error("command kind does not match address byte");
  a_byte_count: assert property (@(posedge ref_clk) disable iff (reset) cmdValid |-> cmdBytes == expBytes)
    else $error("data byte count does not match address byte");
  a_oe_late: assert property (@(posedge serialClk) disable iff (select_low)
    riseCnt < 5'h08 |-> !reply_data_oe)
    else $error("reply output enabled during address byte");
  a_read_drive: assert property (@(posedge serialClk) disable iff (select_low)
    riseCnt == 5'h08 |-> reply_data_oe == (acShift >= READ_FIRST))
    else $error("reply enable does not follow command class");
  a_reply_order: assert property (@(posedge serialClk) disable iff (select_low)
    riseCnt >= 5'h08 && riseCnt <= 5'h17 && reply_data_oe |-> reply_data == shadow[replyIdx])
    else $error("reply bit out of order");
endmodule

`default_nettype wire

// File: tb/host_master_model.sv
// Behavioural host master of the serial control link
`default_nettype none

module host_master_model (
  output logic      serialClk,
  output logic      select_low,
  output logic      cmdData,
  input  wire logic reply_data,
  input  wire logic reply_data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    serialClk  = 1'b0;
    cmdData    = 1'b0;
    // Late rise of select gives the link side a clearing edge
    #1;
    select_low = 1'b1;
  end
  // ----------------------------------------------------------------
  // Frame: clock runs only inside, data changes while clock is low
  // ----------------------------------------------------------------
  task automatic frame(input logic [7:0] ac, input logic [15:0] dw, input int nb, input logic hi,
                       input int gapNs, output logic [15:0] rd);
    logic [23:0] sh;
    sh = (nb == 2) ? {ac, dw} : {ac, dw[7:0], 8'h00};
    rd = 16'h0000;
    serialClk = hi;
    #gapNs;
    select_low = 1'b0;
    #100;
    for (int i = 0; i < 8 + 8 * nb; i++)
    begin
      serialClk = 1'b0;
      cmdData   = sh[23 - i];
      #3;
      serialClk = 1'b1;
      if (i >= 8)
        rd = {rd[14:0], reply_data_oe ? reply_data : 1'bx};
      #3;
    end
    serialClk  = hi;
    #100;
    select_low = 1'b1;
    cmdData    = ~cmdData;
  endtask
  task automatic noise();
    repeat (6)
    begin
      serialClk = ~serialClk;
      cmdData   = ~cmdData;
      #3;
    end
  endtask
endmodule

`default_nettype wire

// File: tb/tb_top.sv
// Top testbench of the host serial control port
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import serial_ctrl_pkg::*;
  logic             ref_clk = 1'b0;
  logic             reset;
  logic             serialClk;
  logic             select_low;
  logic             cmdData;
  logic             reply_data;
  logic             reply_data_oe;
  logic      [15:0] replyWord;
  logic             cmdValid;
  cmd_kind_t        cmdKind;
  logic      [7:0]  cmdAddr;
  logic      [15:0] cmdWord;
  logic      [1:0]  cmdBytes;
  logic             frameError;
  logic             gapShort;
  logic             linkBusy;
  logic      [15:0] rd;
  int               error_cnt = 0;
  int               n_compared = 0;
  int               vCnt = 0;
  int               eCnt = 0;
  int               gCnt = 0;
  int               bCnt = 0;
  always #25 ref_clk = ~ref_clk;
  host_serial_control_port u_dut (.ref_clk, .reset, .serialClk, .select_low, .cmdData, .reply_data,
    .reply_data_oe, .replyWord, .cmdValid, .cmdKind, .cmdAddr, .cmdWord, .cmdBytes, .frameError,
    .gapShort, .linkBusy);
  host_master_model u_host (.serialClk, .select_low, .cmdData, .reply_data, .reply_data_oe);
  always @(posedge ref_clk)
  begin
    vCnt += cmdValid;
    eCnt += frameError;
    gCnt += gapShort;
    bCnt += linkBusy;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] ac, input logic [15:0] dw, input int nb, input logic hi, input logic ok);
    int v0;
    int e0;
    int b0;
    v0 = vCnt;
    e0 = eCnt;
    b0 = bCnt;
    u_host.frame(ac, dw, nb, hi, 1000, rd);
    repeat (10) @(posedge ref_clk);
    #1;
    check(16'(vCnt - v0), {15'h0000, ok});
    check(16'(eCnt - e0), {15'h0000, !ok});
    check(16'(bCnt > b0), 16'h0001);
    check({15'h0000, linkBusy}, 16'h0000);
  endtask
  task automatic fields(input cmd_kind_t k, input logic [7:0] a, input logic [15:0] w, input logic [1:0] b);
    check({14'h0000, cmdKind}, {14'h0000, k});
    check({8'h00, cmdAddr}, {8'h00, a});
    check(cmdWord, w);
    check({14'h0000, cmdBytes}, {14'h0000, b});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_commands();
    xfer(8'hD0, 16'hA55A, 2, 1'b0, 1'b1);
    fields(KIND_WRITE, 8'hD0, 16'hA55A, 2'h2);
    xfer(8'hCF, 16'h0081, 1, 1'b1, 1'b1);
    fields(KIND_WRITE, 8'hCF, 16'h0081, 2'h1);
    xfer(8'h5F, 16'h0000, 0, 1'b0, 1'b1);
    fields(KIND_INSTR, 8'h5F, 16'h0000, 2'h0);
  endtask
  task automatic t_read();
    replyWord = 16'hC3A5;
    xfer(8'hE4, 16'hFFFF, 2, 1'b1, 1'b1);
    check(rd, 16'hC3A5);
    fields(KIND_READ, 8'hE4, 16'hFFFF, 2'h2);
    check({15'h0000, reply_data_oe}, 16'h0000);
    replyWord = 16'h3C5A;
    xfer(8'hFF, 16'h0000, 2, 1'b0, 1'b1);
    check(rd, 16'h3C5A);
  endtask
  task automatic t_errors();
    xfer(8'h60, 16'h1234, 2, 1'b0, 1'b0);
    xfer(8'hD1, 16'h0056, 1, 1'b1, 1'b0);
    check({8'h00, cmdAddr}, 16'h00FF);
  endtask
  task automatic t_noise_gap();
    int g0;
    u_host.noise();
    xfer(8'h9C, 16'h0042, 1, 1'b0, 1'b1);
    fields(KIND_WRITE, 8'h9C, 16'h0042, 2'h1);
    g0 = gCnt;
    u_host.frame(8'h9C, 16'h0024, 1, 1'b0, 0, rd);
    repeat (10) @(posedge ref_clk);
    check(16'(gCnt - g0), 16'h0001);
  endtask
  initial
  begin
    reset     = 1'b0;
    replyWord = 16'h0000;
    #1;
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    t_commands();
    t_read();
    t_errors();
    t_noise_gap();
    print_verdict();
  end
  initial
  begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule

bind host_serial_control_port host_serial_control_port_asserts u_chk (.ref_clk, .reset, .serialClk,
  .select_low, .cmdData, .reply_data, .reply_data_oe, .replyWord, .cmdValid, .cmdKind, .cmdAddr,
  .cmdBytes, .frameError);

`default_nettype wire
